// [pkg/jlc_consts.svh]
// constants for the transmit link control block
`ifndef JLC_CONSTS_SVH
`define JLC_CONSTS_SVH

`define JLC_ADDR_W        12
`define JLC_ADDR_LMC_A    12'h571
`define JLC_ADDR_LMC_B    12'h572
`define JLC_ADDR_LMC_C    12'h573
`define JLC_ADDR_LMC_D    12'h574
`define JLC_ADDR_PHASE    12'h578
`define JLC_ADDR_DID      12'h580
`define JLC_ADDR_BID      12'h581

`define JLC_NREG          7
`define JLC_IX_LMC_A      3'h0
`define JLC_IX_LMC_B      3'h1
`define JLC_IX_LMC_C      3'h2
`define JLC_IX_LMC_D      3'h3
`define JLC_IX_PHASE      3'h4
`define JLC_IX_DID        3'h5
`define JLC_IX_BID        3'h6
`define JLC_IX_NONE       3'h7

`define JLC_RST_LMC_A     8'h14
`define JLC_RST_ZERO      8'h00

// writable bits, the rest are fixed zero
`define JLC_WM_LMC_A      8'hff
`define JLC_WM_LMC_B      8'hf6
`define JLC_WM_LMC_C      8'hf0
`define JLC_WM_LMC_D      8'hf7
`define JLC_WM_PHASE      8'h1f
`define JLC_WM_DID        8'hff
`define JLC_WM_BID        8'h0f

// link mode control a
`define JLC_A_STBY        7
`define JLC_A_TAIL        6
`define JLC_A_LTPL        5
`define JLC_A_LSYNC       4
`define JLC_A_ILAS        3:2
`define JLC_A_FACI_DIS    1
`define JLC_A_PDN         0
// link mode control b
`define JLC_B_SMODE       7:6
`define JLC_B_SPOL        5
`define JLC_B_STYPE       4
`define JLC_B_BYP         2
`define JLC_B_INV         1
// link mode control c
`define JLC_C_SUM         7:6
`define JLC_C_INJ         5:4
// link mode control d, phase and bank id fields
`define JLC_D_DLY         7:4
`define JLC_D_TEST        2:0
`define JLC_PHASE_F       4:0
`define JLC_BID_F         3:0

`define JLC_ILAS_OFF      2'b00
`define JLC_ILAS_ALWAYS   2'b11
`define JLC_SYNC_FORCE_CGS  2'b10
`define JLC_SYNC_FORCE_ILAS 2'b11
`define JLC_SUM_REGS      2'b00
`define JLC_SUM_FIELDS    2'b01
`define JLC_SUM_ZERO      2'b10
`define JLC_INJ_SAMPLE    2'b00
`define JLC_INJ_SYMBOL    2'b01
`define JLC_INJ_OCTET     2'b10
`define JLC_TST_NORMAL    3'b000
`define JLC_TST_D215      3'b001
`define JLC_TST_RPAT      3'b100
`define JLC_TST_JSPAT     3'b101
`define JLC_TST_JTSPAT    3'b110

`define JLC_K28_0         8'h1c
`define JLC_K28_3         8'h7c
`define JLC_K28_4         8'h9c
`define JLC_K28_5         8'hbc
`define JLC_K28_7         8'hfc
`define JLC_D21_5         8'hb5

// four-octet repeating test patterns
`define JLC_PAT_RPAT      32'hbed72347
`define JLC_PAT_JSPAT     32'h7e7e1818
`define JLC_PAT_JTSPAT    32'h7e181818

`define JLC_ILAS_LAST_MF  2'h3
`define JLC_ILAS_CFG_IX0  8'h02
`define JLC_ILAS_CFG_LEN  8'h0e
`define JLC_CFG_IX_DID    4'h0
`define JLC_CFG_IX_BID    4'h1
`define JLC_CFG_IX_SUM    4'hd
`define JLC_PRBS_SEED     9'h1ff
`define JLC_PRBS_W        9

`endif

// [pkg/jlc_pkg.sv]
// types shared by the transmit link control block
package jlc_pkg;

   typedef enum logic [2:0] {
      JLC_ST_OFF  = 3'b000,
      JLC_ST_CGS  = 3'b001,
      JLC_ST_WAIT = 3'b010,
      JLC_ST_ILAS = 3'b011,
      JLC_ST_DATA = 3'b100
   } jlc_state_e;

   typedef struct packed {
      logic       k;
      logic [7:0] d;
   } jlc_oct_s;

   typedef logic [7:0] jlc_byte_t;

endpackage : jlc_pkg

// [hdl/jlc_fifo.sv]
// sample fifo in flip-flops with valid and ready on both sides
`timescale 1ns/1ps
module jlc_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             nrst,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
   logic             full, empty;

   // extra pointer bit tells full from empty
   assign empty     = (wr_q == rd_q);
   assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem_q[rd_q[AW-1:0]];

   always_comb begin
      mem_d = mem_q;
      wr_d  = wr_q;
      rd_d  = rd_q;
      if (in_valid && !full) begin
         mem_d[wr_q[AW-1:0]] = in_data;
         wr_d = wr_q + 1'b1;
      end
      if (out_ready && !empty) begin
         rd_d = rd_q + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wr_q <= '0;
         rd_q <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         mem_q <= mem_d;
      end
   end

endmodule : jlc_fifo

// [hdl/jlc_link_ctrl.sv]
// transmit link layer control: registers, sync handling, lane octet stream
`timescale 1ns/1ps
`include "jlc_consts.svh"
module jlc_link_ctrl #(
   parameter int unsigned SAMPLE_W      = 16,
   parameter int unsigned RES_W         = 14,
   parameter int unsigned CTRL_W        = 0,
   parameter int unsigned FRAMES_PER_MF = 32,
   parameter int unsigned FIFO_DEPTH    = 8
) (
   input  wire logic                  clk_sys,
   input  wire logic                  nrst,
   input  wire logic [`JLC_ADDR_W-1:0] reg_addr,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   input  wire logic [7:0]            reg_wdata,
   output logic      [7:0]            reg_rdata,
   input  wire logic                  s_valid,
   input  wire logic [SAMPLE_W-1:0]   s_data,
   output logic                       s_ready,
   input  wire logic                  sync_request_input,
   output logic                       sync_cmos_sel,
   input  wire logic                  standby_req,
   input  wire logic                  test_inject_en,
   input  wire logic [SAMPLE_W-1:0]   test_data,
   output jlc_pkg::jlc_oct_s          tx_oct,
   input  wire logic [9:0]            enc_symbol,
   output logic      [9:0]            ser_symbol,
   output logic                       lane_active,
   output logic                       lmfc_tick,
   output jlc_pkg::jlc_state_e        link_state
);
   localparam int unsigned F      = SAMPLE_W / 8;
   localparam int unsigned OCT_W  = (F > 1) ? $clog2(F) : 1;
   localparam int unsigned MF_OCT = F * FRAMES_PER_MF;
   localparam int unsigned IDX_W  = $clog2(MF_OCT);
   localparam int unsigned TAIL_W = SAMPLE_W - RES_W - CTRL_W;
   localparam logic [IDX_W-1:0] LAST_IX  = IDX_W'(MF_OCT - 1);
   localparam logic [OCT_W-1:0] LAST_OCT = OCT_W'(F - 1);

   // ---------------- register file ----------------
   jlc_pkg::jlc_byte_t regs_q [`JLC_NREG];
   jlc_pkg::jlc_byte_t regs_d [`JLC_NREG];
   logic [7:0]         rdata_q, rdata_d;

   function automatic logic [2:0] reg_index(input logic [`JLC_ADDR_W-1:0] a);
      case (a)
         `JLC_ADDR_LMC_A: reg_index = `JLC_IX_LMC_A;
         `JLC_ADDR_LMC_B: reg_index = `JLC_IX_LMC_B;
         `JLC_ADDR_LMC_C: reg_index = `JLC_IX_LMC_C;
         `JLC_ADDR_LMC_D: reg_index = `JLC_IX_LMC_D;
         `JLC_ADDR_PHASE: reg_index = `JLC_IX_PHASE;
         `JLC_ADDR_DID:   reg_index = `JLC_IX_DID;
         `JLC_ADDR_BID:   reg_index = `JLC_IX_BID;
         default:         reg_index = `JLC_IX_NONE;
      endcase
   endfunction : reg_index

   function automatic logic [7:0] write_mask(input logic [2:0] ix);
      case (ix)
         `JLC_IX_LMC_A: write_mask = `JLC_WM_LMC_A;
         `JLC_IX_LMC_B: write_mask = `JLC_WM_LMC_B;
         `JLC_IX_LMC_C: write_mask = `JLC_WM_LMC_C;
         `JLC_IX_LMC_D: write_mask = `JLC_WM_LMC_D;
         `JLC_IX_PHASE: write_mask = `JLC_WM_PHASE;
         `JLC_IX_DID:   write_mask = `JLC_WM_DID;
         `JLC_IX_BID:   write_mask = `JLC_WM_BID;
         default:       write_mask = `JLC_RST_ZERO;
      endcase
   endfunction : write_mask

   always_comb begin
      logic [2:0] wix;
      logic [2:0] rix;
      wix     = reg_index(reg_addr);
      rix     = reg_index(reg_addr);
      regs_d  = regs_q;
      rdata_d = rdata_q;
      if (reg_wr && wix != `JLC_IX_NONE) begin
         regs_d[wix] = reg_wdata & write_mask(wix);
      end
      if (reg_rd) begin
         rdata_d = (rix == `JLC_IX_NONE) ? `JLC_RST_ZERO : regs_q[rix];
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         regs_q[`JLC_IX_LMC_A] <= `JLC_RST_LMC_A;
         for (int i = 1; i < `JLC_NREG; i++) begin
            regs_q[i] <= `JLC_RST_ZERO;
         end
         rdata_q <= `JLC_RST_ZERO;
      end else begin
         regs_q  <= regs_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   logic       cfg_stby, cfg_tail, cfg_ltpl, cfg_lsync, cfg_faci_dis, cfg_pdn;
   logic       cfg_spol, cfg_byp, cfg_inv;
   logic [1:0] cfg_ilas, cfg_smode, cfg_sum, cfg_inj;
   logic [3:0] cfg_dly;
   logic [2:0] cfg_test;
   logic [4:0] cfg_phase;
   logic [7:0] cfg_did, cfg_bid;

   assign cfg_stby     = regs_q[`JLC_IX_LMC_A][`JLC_A_STBY];
   assign cfg_tail     = regs_q[`JLC_IX_LMC_A][`JLC_A_TAIL];
   assign cfg_ltpl     = regs_q[`JLC_IX_LMC_A][`JLC_A_LTPL];
   assign cfg_lsync    = regs_q[`JLC_IX_LMC_A][`JLC_A_LSYNC];
   assign cfg_ilas     = regs_q[`JLC_IX_LMC_A][`JLC_A_ILAS];
   assign cfg_faci_dis = regs_q[`JLC_IX_LMC_A][`JLC_A_FACI_DIS];
   assign cfg_pdn      = regs_q[`JLC_IX_LMC_A][`JLC_A_PDN];
   assign cfg_smode    = regs_q[`JLC_IX_LMC_B][`JLC_B_SMODE];
   assign cfg_spol     = regs_q[`JLC_IX_LMC_B][`JLC_B_SPOL];
   assign cfg_byp      = regs_q[`JLC_IX_LMC_B][`JLC_B_BYP];
   assign cfg_inv      = regs_q[`JLC_IX_LMC_B][`JLC_B_INV];
   assign cfg_sum      = regs_q[`JLC_IX_LMC_C][`JLC_C_SUM];
   assign cfg_inj      = regs_q[`JLC_IX_LMC_C][`JLC_C_INJ];
   assign cfg_dly      = regs_q[`JLC_IX_LMC_D][`JLC_D_DLY];
   assign cfg_test     = regs_q[`JLC_IX_LMC_D][`JLC_D_TEST];
   assign cfg_phase    = regs_q[`JLC_IX_PHASE][`JLC_PHASE_F];
   assign cfg_did      = regs_q[`JLC_IX_DID];
   assign cfg_bid      = regs_q[`JLC_IX_BID];

   assign sync_cmos_sel = regs_q[`JLC_IX_LMC_B][`JLC_B_STYPE];

   // ---------------- sync request pin ----------------
   logic s1_q, s2_q, s3_q, slvl_q;
   logic s1_d, s2_d, s3_d, slvl_d;
   logic sync_req;

   always_comb begin
      s1_d   = sync_request_input;
      s2_d   = s1_q;
      s3_d   = s2_q;
      // a change counts only once two stages agree
      slvl_d = (s2_q == s3_q) ? s3_q : slvl_q;
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         s1_q   <= 1'b1;
         s2_q   <= 1'b1;
         s3_q   <= 1'b1;
         slvl_q <= 1'b1;
      end else begin
         s1_q   <= s1_d;
         s2_q   <= s2_d;
         s3_q   <= s3_d;
         slvl_q <= slvl_d;
      end
   end

   always_comb begin
      case (cfg_smode)
         `JLC_SYNC_FORCE_CGS:  sync_req = 1'b1;
         `JLC_SYNC_FORCE_ILAS: sync_req = 1'b0;
         default:              sync_req = cfg_spol ? slvl_q : !slvl_q;
      endcase
   end

   // ---------------- sample fifo ----------------
   logic                fifo_valid, fifo_pop;
   logic [SAMPLE_W-1:0] fifo_data;

   jlc_fifo #(
      .WIDTH (SAMPLE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .nrst      (nrst),
      .in_valid  (s_valid),
      .in_data   (s_data),
      .in_ready  (s_ready),
      .out_valid (fifo_valid),
      .out_data  (fifo_data),
      .out_ready (fifo_pop)
   );

   // ---------------- link sequencing ----------------
   jlc_pkg::jlc_state_e state_q, state_d;
   logic [IDX_W-1:0]    pos_q, pos_d;
   logic [3:0]          wait_q, wait_d;
   logic [1:0]          mf_q, mf_d;
   logic [SAMPLE_W-1:0] smp_q, smp_d;
   logic [7:0]          last_q, last_d;
   logic [`JLC_PRBS_W-1:0] prbs_q, prbs_d;
   jlc_pkg::jlc_oct_s   tx_q, tx_d;
   logic [9:0]          ser_q, ser_d;
   logic                tick_q, tick_d;

   logic [IDX_W-1:0] off_pos, rel;
   logic [OCT_W-1:0] oct;
   logic             pre_bound, last_frame;

   assign off_pos    = IDX_W'(cfg_phase * F);
   assign rel        = pos_q - off_pos;
   assign oct        = rel[OCT_W-1:0];
   assign pre_bound  = (rel == LAST_IX);
   assign last_frame = &rel[IDX_W-1:OCT_W];
   assign fifo_pop   = (state_q == jlc_pkg::JLC_ST_DATA) && (oct == '0);

   function automatic logic [7:0] cfg_octet(input logic [3:0] ix, input logic [7:0] did,
                                            input logic [7:0] bid, input logic [1:0] mode);
      logic [7:0] sum;
      sum = (mode == `JLC_SUM_REGS)   ? did + bid :
            (mode == `JLC_SUM_FIELDS) ? did + {4'h0, bid[`JLC_BID_F]} :
                                        `JLC_RST_ZERO;
      case (ix)
         `JLC_CFG_IX_DID: cfg_octet = did;
         `JLC_CFG_IX_BID: cfg_octet = bid;
         `JLC_CFG_IX_SUM: cfg_octet = sum;
         default:         cfg_octet = `JLC_RST_ZERO;
      endcase
   endfunction : cfg_octet

   function automatic logic [7:0] pat_octet(input logic [31:0] pat, input logic [1:0] ix);
      pat_octet = pat[{~ix, 3'h0} +: 8];
   endfunction : pat_octet

   always_comb begin
      logic [SAMPLE_W-1:0] fresh, cur;
      logic [7:0]          d8, ix8;
      fresh   = fifo_valid ? fifo_data : '0;
      cur     = '0;
      d8      = '0;
      ix8     = 8'(rel);
      state_d = state_q;
      pos_d   = pos_q + 1'b1;
      wait_d  = wait_q;
      mf_d    = mf_q;
      smp_d   = smp_q;
      last_d  = last_q;
      prbs_d  = prbs_q;
      tx_d    = '{k: 1'b0, d: `JLC_RST_ZERO};
      tick_d  = pre_bound;

      // next sample, with substitutions applied in priority order
      if (cfg_ltpl) begin
         fresh = SAMPLE_W'(rel[IDX_W-1:OCT_W]);
      end else if (test_inject_en && cfg_inj == `JLC_INJ_SAMPLE) begin
         fresh = test_data;
      end
      if (cfg_tail && !cfg_ltpl) begin
         for (int i = 0; i < TAIL_W; i++) begin
            fresh[i] = prbs_q[i % `JLC_PRBS_W];
         end
      end
      cur = (oct == '0) ? fresh : smp_q;
      d8  = cur[(F - 1 - oct) * 8 +: 8];

      case (state_q)
         jlc_pkg::JLC_ST_OFF: begin
            if (!cfg_pdn) state_d = jlc_pkg::JLC_ST_CGS;
         end
         jlc_pkg::JLC_ST_CGS: begin
            if (!sync_req) begin
               state_d = jlc_pkg::JLC_ST_WAIT;
               wait_d  = '0;
            end
         end
         jlc_pkg::JLC_ST_WAIT: begin
            if (sync_req) begin
               state_d = jlc_pkg::JLC_ST_CGS;
            end else if (pre_bound) begin
               if (wait_q == cfg_dly) begin
                  state_d = (cfg_ilas == `JLC_ILAS_OFF) ? jlc_pkg::JLC_ST_DATA
                                                        : jlc_pkg::JLC_ST_ILAS;
                  mf_d    = '0;
               end else begin
                  wait_d = wait_q + 1'b1;
               end
            end
         end
         jlc_pkg::JLC_ST_ILAS: begin
            if (sync_req) begin
               state_d = jlc_pkg::JLC_ST_CGS;
            end else if (pre_bound) begin
               mf_d = mf_q + 1'b1;
               if (mf_q == `JLC_ILAS_LAST_MF && cfg_ilas != `JLC_ILAS_ALWAYS) begin
                  state_d = jlc_pkg::JLC_ST_DATA;
               end
            end
         end
         jlc_pkg::JLC_ST_DATA: begin
            if (sync_req) state_d = jlc_pkg::JLC_ST_CGS;
         end
         default: state_d = jlc_pkg::JLC_ST_OFF;
      endcase
      if (cfg_pdn) begin
         state_d = jlc_pkg::JLC_ST_OFF;
         pos_d   = '0;
      end

      // octet content
      if (state_q == jlc_pkg::JLC_ST_OFF) begin
         tx_d = '{k: 1'b0, d: `JLC_RST_ZERO};
      end else if (standby_req) begin
         tx_d = cfg_stby ? '{k: 1'b1, d: `JLC_K28_5}
                         : '{k: 1'b0, d: `JLC_RST_ZERO};
      end else if (cfg_test != `JLC_TST_NORMAL) begin
         case (cfg_test)
            `JLC_TST_D215:   tx_d.d = `JLC_D21_5;
            `JLC_TST_RPAT:   tx_d.d = pat_octet(`JLC_PAT_RPAT, rel[1:0]);
            `JLC_TST_JSPAT:  tx_d.d = pat_octet(`JLC_PAT_JSPAT, rel[1:0]);
            `JLC_TST_JTSPAT: tx_d.d = pat_octet(`JLC_PAT_JTSPAT, rel[1:0]);
            default:         tx_d.d = `JLC_RST_ZERO;
         endcase
      end else begin
         case (state_q)
            jlc_pkg::JLC_ST_CGS, jlc_pkg::JLC_ST_WAIT: begin
               tx_d = '{k: 1'b1, d: `JLC_K28_5};
            end
            jlc_pkg::JLC_ST_ILAS: begin
               if (rel == '0) begin
                  tx_d = '{k: 1'b1, d: `JLC_K28_0};
               end else if (pre_bound) begin
                  tx_d = '{k: 1'b1, d: `JLC_K28_3};
               end else if (mf_q == 2'h1 && rel == IDX_W'(1)) begin
                  tx_d = '{k: 1'b1, d: `JLC_K28_4};
               end else if (mf_q == 2'h1 && ix8 >= `JLC_ILAS_CFG_IX0 &&
                            ix8 < `JLC_ILAS_CFG_IX0 + `JLC_ILAS_CFG_LEN) begin
                  tx_d.d = cfg_octet(4'(ix8 - `JLC_ILAS_CFG_IX0), cfg_did, cfg_bid, cfg_sum);
               end else begin
                  tx_d.d = ix8;
               end
            end
            jlc_pkg::JLC_ST_DATA: begin
               tx_d.d = d8;
               if (test_inject_en && cfg_inj == `JLC_INJ_OCTET) begin
                  tx_d.d = test_data[7:0];
               end
               // alignment character only where the frame repeats the last octet
               if (oct == LAST_OCT) begin
                  last_d = tx_d.d;
                  if (!cfg_faci_dis && tx_d.d == last_q) begin
                     tx_d.k = 1'b1;
                     tx_d.d = (cfg_lsync && last_frame) ? `JLC_K28_3 : `JLC_K28_7;
                  end
               end
            end
            default: tx_d = '{k: 1'b0, d: `JLC_RST_ZERO};
         endcase
      end

      if (fifo_pop) begin
         smp_d  = fresh;
         prbs_d = {prbs_q[`JLC_PRBS_W-2:0], prbs_q[8] ^ prbs_q[4]};
      end

      // symbol stage works on the octet registered last cycle
      ser_d = cfg_byp ? {2'b00, tx_q.d} : enc_symbol;
      if (test_inject_en && cfg_inj == `JLC_INJ_SYMBOL) begin
         ser_d = test_data[9:0];
      end
      if (cfg_inv) ser_d = ~ser_d;
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_q <= jlc_pkg::JLC_ST_OFF;
         pos_q   <= '0;
         wait_q  <= '0;
         mf_q    <= '0;
         smp_q   <= '0;
         last_q  <= '0;
         prbs_q  <= `JLC_PRBS_SEED;
         tx_q    <= '{k: 1'b0, d: `JLC_RST_ZERO};
         ser_q   <= '0;
         tick_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         pos_q   <= pos_d;
         wait_q  <= wait_d;
         mf_q    <= mf_d;
         smp_q   <= smp_d;
         last_q  <= last_d;
         prbs_q  <= prbs_d;
         tx_q    <= tx_d;
         ser_q   <= ser_d;
         tick_q  <= tick_d;
      end
   end

   assign tx_oct      = tx_q;
   assign ser_symbol  = ser_q;
   assign lmfc_tick   = tick_q;
   assign link_state  = state_q;
   assign lane_active = (state_q != jlc_pkg::JLC_ST_OFF);

endmodule : jlc_link_ctrl

// [testbench/jlc_link_checker.sv]
// port-level checks for the transmit link control block
`timescale 1ns/1ps
`include "jlc_consts.svh"
module jlc_link_checker #(parameter int FRAMES_PER_MF = 8) (
   input logic                   clk_sys,
   input logic                   nrst,
   input logic [`JLC_ADDR_W-1:0] reg_addr,
   input logic                   reg_wr,
   input logic                   reg_rd,
   input logic [7:0]             reg_wdata,
   input logic [7:0]             reg_rdata,
   input logic                   sync_request_input,
   input logic                   sync_cmos_sel,
   input logic                   test_inject_en,
   input jlc_pkg::jlc_oct_s      tx_oct,
   input logic [9:0]             enc_symbol,
   input logic [9:0]             ser_symbol,
   input logic                   lane_active,
   input logic                   lmfc_tick,
   input jlc_pkg::jlc_state_e    link_state
);
   localparam int MF_LEN = 2 * FRAMES_PER_MF;
   logic [7:0] lmc_b_d, lmc_b_q;
   logic       req_on;
   always_comb begin
      lmc_b_d = lmc_b_q;
      if (reg_wr && reg_addr == `JLC_ADDR_LMC_B) lmc_b_d = reg_wdata & `JLC_WM_LMC_B;
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) lmc_b_q <= 8'h00;
      else lmc_b_q <= lmc_b_d;
   end
   assign req_on = sync_request_input == lmc_b_q[5];
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // long enough to cover the input filter lag
   sequence req_held_s;
      (req_on && lmc_b_q[7:6] == 2'b00 && lane_active) [*6];
   endsequence
   lane_flag_a: assert property (lane_active == (link_state != jlc_pkg::JLC_ST_OFF))
      else $error("lane flag disagrees with state");
   off_zero_a: assert property (!lane_active [*2] |-> tx_oct == 9'h000)
      else $error("octets not zero while powered down");
   cmos_sel_a: assert property (reg_wr && reg_addr == `JLC_ADDR_LMC_B
      |=> sync_cmos_sel == $past(reg_wdata[4])) else $error("pin type select wrong");
   sym_path_a: assert property (lane_active && !test_inject_en |=> ser_symbol ==
      (($past(lmc_b_q[2]) ? {2'b00, $past(tx_oct.d)} : $past(enc_symbol))
      ^ {10{$past(lmc_b_q[1])}})) else $error("lane symbol path wrong");
   lmfc_period_a: assert property (lmfc_tick |-> ##MF_LEN (lmfc_tick || !lane_active))
      else $error("multiframe tick period wrong");
   force_cgs_a: assert property ((lmc_b_q[7:6] == 2'b10 && lane_active) [*3]
      |-> link_state == jlc_pkg::JLC_ST_CGS) else $error("forced sync not in CGS");
   sync_cgs_a: assert property (req_held_s |-> link_state == jlc_pkg::JLC_ST_CGS)
      else $error("sync request not obeyed");
   bid_upper_a: assert property (reg_rd && reg_addr == `JLC_ADDR_BID
      |=> reg_rdata[7:4] == 4'h0) else $error("bank id upper bits not zero");
endmodule : jlc_link_checker
bind jlc_link_ctrl jlc_link_checker #(.FRAMES_PER_MF(FRAMES_PER_MF)) i_jlc_link_checker (
   .clk_sys, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .sync_request_input,
   .sync_cmos_sel, .test_inject_en, .tx_oct, .enc_symbol, .ser_symbol, .lane_active,
   .lmfc_tick, .link_state);

// [testbench/jlc_rx_model.sv]
// receiver side: holds sync request until enough K28.5 octets arrive
`timescale 1ns/1ps
`include "jlc_consts.svh"
module jlc_rx_model #(parameter int GOOD_CNT = 4) (
   input  logic              clk_sys,
   input  logic              resync,
   input  logic              pol,
   input  jlc_pkg::jlc_oct_s tx_oct,
   output logic              sync_request_input
);
   int cnt = 0;
   always @(posedge clk_sys) begin
      if (resync) cnt <= 0;
      else if (tx_oct.k && tx_oct.d == `JLC_K28_5 && cnt < GOOD_CNT) cnt <= cnt + 1;
   end
   assign sync_request_input = (cnt < GOOD_CNT) ~^ pol;
endmodule : jlc_rx_model

// [testbench/jlc_link_ctrl_bench.sv]
// register-driven bench for the transmit link control block
`timescale 1ns/1ps
module jlc_link_ctrl_bench;
   logic clk_sys = 0, nrst = 0, reg_wr = 0, reg_rd = 0, s_valid = 0, standby_req = 0;
   logic test_inject_en = 0, resync = 1, pol = 0, sync_request_input, sync_cmos_sel;
   logic s_ready, lane_active, lmfc_tick, ok;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, v;
   logic [15:0] s_data = 16'h0000, test_data = 16'h0000;
   logic [9:0] enc_symbol = 10'h000, ser_symbol;
   jlc_pkg::jlc_oct_s tx_oct;
   jlc_pkg::jlc_state_e link_state;
   int num_errors = 0, n_compared = 0, cyc = 0;
   logic [11:0] adr [7] = '{12'h571, 12'h572, 12'h573, 12'h574, 12'h578, 12'h580, 12'h581};
   logic [7:0] msk [7] = '{8'hff, 8'hf6, 8'hf0, 8'hf7, 8'h1f, 8'hff, 8'h0f};
   logic [7:0] cfg [7] = '{8'h14, 8'h30, 8'h00, 8'h10, 8'h00, 8'h5a, 8'h03};
   logic [2:0] tcode [4] = '{3'b001, 3'b100, 3'b101, 3'b110};
   logic [31:0] pat [4] = '{32'hb5b5b5b5, 32'hbed72347, 32'h7e7e1818, 32'h7e181818}, w;
   jlc_link_ctrl #(.FRAMES_PER_MF(16)) i_jlc_link_ctrl (.clk_sys, .nrst, .reg_addr, .reg_wr,
      .reg_rd, .reg_wdata, .reg_rdata, .s_valid, .s_data, .s_ready, .sync_request_input,
      .sync_cmos_sel, .standby_req, .test_inject_en, .test_data, .tx_oct, .enc_symbol,
      .ser_symbol, .lane_active, .lmfc_tick, .link_state);
   jlc_rx_model i_jlc_rx_model (.clk_sys, .resync, .pol, .tx_oct, .sync_request_input);
   initial forever #10 clk_sys = ~clk_sys;
   // stand-in encoder, top bit set so bypass shows
   always @(negedge clk_sys) enc_symbol <= {1'b1, tx_oct};
   always @(posedge clk_sys) if (++cyc == 30000) begin
      num_errors++;
      complete_run;
   end
   task automatic chk(input string nm, input logic [15:0] s, e);
      n_compared++;
      if (s !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge clk_sys) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(negedge clk_sys) reg_wr = 0;
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      @(negedge clk_sys) {reg_addr, reg_rd} = {a, 1'b1};
      @(negedge clk_sys) reg_rd = 0;
      d = reg_rdata;
   endtask : rd
   task automatic wait_st(input jlc_pkg::jlc_state_e st);
      for (int i = 0; i < 500 && link_state !== st; i++) @(negedge clk_sys);
   endtask : wait_st
   task automatic wait_tick;
      for (int i = 0; i < 41 && (i == 0 || lmfc_tick !== 1'b1); i++) @(negedge clk_sys);
      @(negedge clk_sys);
   endtask : wait_tick
   task automatic complete_run;
      if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   initial begin
      repeat (12) @(negedge clk_sys);
      nrst = 1;
      for (int i = 0; i < 7; i++) begin
         rd(adr[i], v);
         chk("reset value", v, i == 0 ? 8'h14 : 8'h00);
      end
      rd(12'h575, v);
      chk("unmapped read", v, 8'h00);
      for (int i = 0; i < 7; i++) wr(adr[i], 8'hff);
      chk("powered down", {lane_active, tx_oct}, 10'h000);
      for (int i = 0; i < 7; i++) begin
         rd(adr[i], v);
         chk("masked write", v, msk[i]);
      end
      pol = 1;
      for (int i = 6; i >= 0; i--) wr(adr[i], cfg[i]);
      chk("pin type", sync_cmos_sel, 1'b1);
      // fill while the link cannot drain it
      for (int i = 0; i < 8; i++) @(negedge clk_sys)
         {s_valid, s_data} = {1'b1, 8'h11 * 8'(i + 1), 8'(i)};
      @(negedge clk_sys) s_valid = 0;
      chk("fifo full", s_ready, 1'b0);
      for (int m = 0; m < 3; m++) begin
         resync = 1;
         wr(12'h573, 8'(m << 6));
         repeat (8) @(negedge clk_sys);
         chk("sync octet", tx_oct, {1'b1, 8'hbc});
         resync = 0;
         wait_st(jlc_pkg::JLC_ST_WAIT);
         wait_tick;
         chk("first boundary", tx_oct, {1'b1, 8'hbc});
         wait_tick;
         chk("ilas start", tx_oct, {1'b1, 8'h1c});
         wait_tick;
         repeat (2) @(negedge clk_sys);
         chk("device id", tx_oct.d, 8'h5a);
         @(negedge clk_sys) chk("bank id", tx_oct.d, 8'h03);
         repeat (12) @(negedge clk_sys);
         chk("checksum", tx_oct.d, m == 2 ? 8'h00 : 8'h5d);
         wait_st(jlc_pkg::JLC_ST_DATA);
         for (int i = 0; i < 8 && m == 0; i++) begin
            for (int j = 0; j < 40 && tx_oct.d !== 8'(8'h11 * (i + 1)); j++) @(negedge clk_sys);
            chk("sample msb", tx_oct, {1'b0, 8'(8'h11 * (i + 1))});
            @(negedge clk_sys) chk("sample lsb", tx_oct, i ? {1'b0, 8'(i)} : 9'h1fc);
         end
      end
      for (int t = 0; t < 4; t++) begin
         wr(12'h574, {5'h02, tcode[t]});
         repeat (4) @(negedge clk_sys);
         for (int j = 0; j < 4; j++) @(negedge clk_sys) w = {w[23:0], tx_oct.d};
         ok = 0;
         for (int r = 0; r < 4; r++) ok |= (w === 32'({pat[t], pat[t]} >> (8 * r)));
         chk("test pattern", ok, 1'b1);
      end
      wr(12'h574, 8'h10);
      standby_req = 1;
      repeat (3) @(negedge clk_sys);
      chk("standby zeros", tx_oct, 9'h000);
      wr(12'h571, 8'h94);
      repeat (2) @(negedge clk_sys);
      chk("standby sync", tx_oct, {1'b1, 8'hbc});
      standby_req = 0;
      wr(12'h572, 8'h34);
      repeat (2) @(negedge clk_sys);
      chk("bypass", ser_symbol[9:8], 2'b00);
      {test_inject_en, test_data} = {1'b1, 16'h0155};
      wr(12'h573, 8'h10);
      wr(12'h572, 8'h32);
      repeat (2) @(negedge clk_sys);
      chk("inject invert", ser_symbol, 10'h2aa);
      test_inject_en = 0;
      wr(12'h572, 8'hb0);
      repeat (4) @(negedge clk_sys);
      chk("forced sync", link_state, jlc_pkg::JLC_ST_CGS);
      wr(12'h572, 8'hf0);
      wait_st(jlc_pkg::JLC_ST_DATA);
      chk("forced ilas", link_state, jlc_pkg::JLC_ST_DATA);
      complete_run;
   end
endmodule : jlc_link_ctrl_bench
